//--- rtl/psm_pkg.sv
package psm_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_EDPD = 5'h04;
    localparam logic [4:0] OFS_DEBUG = 5'h08;
    localparam logic [4:0] OFS_STRAP = 5'h0c;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    localparam logic [4:0] OFS_EVENT = 5'h14;
    // ctrl fields
    localparam int CTRL_PD = 0;
    localparam int CTRL_ISO = 1;
    localparam int CTRL_FGIG = 2;
    // edpd fields
    localparam int EDPD_EN = 0;
    localparam int EDPD_MASK = 1;
    localparam int EDPD_TIMER = 3;
    localparam int EDPD_RND_DIS = 5;
    localparam int EDPD_PSEL_EN = 6;
    localparam int EDPD_PSEL = 7;
    // debug fields
    localparam int DBG_OVR = 0;
    localparam int DBG_SPD_PLL = 1;
    localparam int DBG_ED_PLL = 2;
    localparam int DBG_XTAL = 3;
    // strap override fields
    localparam int STRAP_DIS_MODE = 0;
    localparam int STRAP_EN_MODE = 1;
    // status fields
    localparam int ST_LOWPWR = 0;
    localparam int ST_ENERGY = 1;
    localparam int ST_COMA = 2;
    localparam int ST_PD = 3;
    localparam int ST_PLL = 4;
    localparam int ST_ICLK = 5;
    localparam int ST_TRIM = 6;
    // event fields
    localparam int EV_ENERGY = 0;
    localparam int EV_LINK = 1;
    // mode straps
    localparam logic [4:0] STRAP_SPD_PLL_ON = 5'h08;
    localparam logic [4:0] STRAP_SPD_PLL_OFF = 5'h09;
    // reset values
    localparam logic RST_PD = 1'b0;
    localparam logic RST_EDPD_EN = 1'b0;
    localparam logic RST_PLL_OFF_BITS = 1'b0;
    // smart power threshold, meters
    localparam logic [7:0] SHORT_CABLE_M = 8'h46;
    // timing
    localparam int CLK_MHZ = 250;
    localparam int EDPD_PULSE_US = 1000;
    localparam int EDPD_MASK_US = 100;
    localparam int PULSE_CYC = EDPD_PULSE_US * CLK_MHZ;
    localparam int MASK_CYC = EDPD_MASK_US * CLK_MHZ;
endpackage

//--- rtl/psm_power_manager.sv
`timescale 1ns/1ps
module psm_power_manager #(
    parameter int PULSE_CYCLES = psm_pkg::PULSE_CYC,
    parameter int MASK_CYCLES = psm_pkg::MASK_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic coma_hold,
    input wire logic [4:0] mode_strap,
    input wire logic [3:0] energy_pairs,
    input wire logic [7:0] cable_len_m,
    input wire logic cable_len_valid,
    input wire logic link_up_in,
    input wire logic [1:0] led_req,
    input wire logic irq_req,
    output logic rx_path_enable,
    output logic tx_path_enable,
    output logic rec_clk_enable,
    output logic [1:0] led_out,
    output logic irq_out,
    output logic link_status,
    output logic link_pulse,
    output logic power_trim,
    output logic pll_enable,
    output logic crystal_enable,
    output logic int_clk_enable,
    output logic txrx_clk_enable,
    output logic mmd_access_ok,
    output logic mmd1_access_ok,
    output logic mgmt_alive,
    output logic device_reset
);
    localparam logic [27:0] PULSE_W = 28'(PULSE_CYCLES);
    localparam logic [23:0] MASK_W = 24'(MASK_CYCLES);

    // shifted interval plus jitter must fit 28 bits, four mask spans 24 bits
    generate
        if (PULSE_CYCLES < 1 || PULSE_CYCLES > 2 ** 24) begin : g_bad_pulse
            $error("psm_power_manager: pulse interval out of range");
        end
        if (MASK_CYCLES < 1 || MASK_CYCLES > 2 ** 21) begin : g_bad_mask
            $error("psm_power_manager: mask time out of range");
        end
    endgenerate

    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic strap_done;
        logic dev_rst;
        logic power_down;
        logic isolate;
        logic force_gig;
        logic edpd_en;
        logic [1:0] mask_timer;
        logic [1:0] edpd_timer;
        logic random_dis;
        logic pair_sel_en;
        logic [1:0] pair_sel;
        logic gate_override;
        logic spd_pll_disable;
        logic energy_sleep_pll_off;
        logic crystal_osc_disable;
        logic spd_pll_dis_mode;
        logic spd_pll_en_mode;
        logic [1:0] evt;
        logic energy;
        logic link_seen;
        logic xtal_locked;
        logic pll_off;
        logic [27:0] pulse_cnt;
        logic [23:0] mask_cnt;
        logic [7:0] lfsr;
        logic o_rx;
        logic o_tx;
        logic o_rclk;
        logic [1:0] o_led;
        logic o_irq;
        logic o_link;
        logic o_pulse;
        logic o_trim;
        logic o_xtal;
        logic o_iclk;
        logic o_txrx;
        logic o_mmd;
        logic o_mmd1;
        logic o_pll;
    } psm_state_t;

    psm_state_t s;
    psm_state_t n;

    // soft reset restores controls; strap override bits and lock survive
    function automatic psm_state_t psm_defaults(input psm_state_t st);
        psm_state_t d;
        d = st;
        d.power_down = st.spd_pll_dis_mode | st.spd_pll_en_mode;
        d.spd_pll_disable = st.spd_pll_dis_mode;
        d.isolate = 1'b0;
        d.force_gig = 1'b0;
        d.edpd_en = psm_pkg::RST_EDPD_EN;
        d.mask_timer = 2'h0;
        d.edpd_timer = 2'h0;
        d.random_dis = 1'b0;
        d.pair_sel_en = 1'b0;
        d.pair_sel = 2'h0;
        d.gate_override = 1'b0;
        d.energy_sleep_pll_off = psm_pkg::RST_PLL_OFF_BITS;
        d.crystal_osc_disable = 1'b0;
        d.evt = 2'h0;
        return d;
    endfunction

    // port sleeps while enabled and no partner energy is seen
    function automatic logic psm_asleep(input logic en, input logic energy);
        return en && !energy;
    endfunction

    logic [31:0] rd_val;
    logic [3:0] mon_mask;
    logic raw_energy;
    logic sleep;
    logic off_now;
    logic coma_free;
    logic [23:0] mask_target;
    logic [27:0] pulse_target;

    always_comb begin
        n = s;
        n.o_pulse = 1'b0;
        n.dev_rst = 1'b0;

        // register read image
        rd_val = 32'h0000_0000;
        unique case (avs_address)
            psm_pkg::OFS_CTRL: begin
                rd_val[psm_pkg::CTRL_PD] = s.power_down;
                rd_val[psm_pkg::CTRL_ISO] = s.isolate;
                rd_val[psm_pkg::CTRL_FGIG] = s.force_gig;
            end
            psm_pkg::OFS_EDPD: begin
                rd_val[psm_pkg::EDPD_EN] = s.edpd_en;
                rd_val[psm_pkg::EDPD_MASK +: 2] = s.mask_timer;
                rd_val[psm_pkg::EDPD_TIMER +: 2] = s.edpd_timer;
                rd_val[psm_pkg::EDPD_RND_DIS] = s.random_dis;
                rd_val[psm_pkg::EDPD_PSEL_EN] = s.pair_sel_en;
                rd_val[psm_pkg::EDPD_PSEL +: 2] = s.pair_sel;
            end
            psm_pkg::OFS_DEBUG: begin
                rd_val[psm_pkg::DBG_OVR] = s.gate_override;
                rd_val[psm_pkg::DBG_SPD_PLL] = s.spd_pll_disable;
                rd_val[psm_pkg::DBG_ED_PLL] = s.energy_sleep_pll_off;
                rd_val[psm_pkg::DBG_XTAL] = s.crystal_osc_disable;
            end
            psm_pkg::OFS_STRAP: begin
                rd_val[psm_pkg::STRAP_DIS_MODE] = s.spd_pll_dis_mode;
                rd_val[psm_pkg::STRAP_EN_MODE] = s.spd_pll_en_mode;
            end
            psm_pkg::OFS_STATUS: begin
                rd_val[psm_pkg::ST_LOWPWR] = psm_asleep(s.edpd_en, s.energy);
                rd_val[psm_pkg::ST_ENERGY] = s.energy;
                rd_val[psm_pkg::ST_COMA] = coma_hold;
                rd_val[psm_pkg::ST_PD] = s.power_down;
                rd_val[psm_pkg::ST_PLL] = ~s.pll_off;
                rd_val[psm_pkg::ST_ICLK] = s.o_iclk;
                rd_val[psm_pkg::ST_TRIM] = s.o_trim;
            end
            psm_pkg::OFS_EVENT: rd_val[1:0] = s.evt;
            default: rd_val = 32'h0000_0000;
        endcase
        // management dies with the crystal
        if (s.xtal_locked) begin
            rd_val = 32'h0000_0000;
        end

        // one wait cycle, then a single answer cycle
        if (s.waitreq) begin
            if (avs_read || avs_write) begin
                n.waitreq = 1'b0;
                n.rdata = avs_read ? rd_val : 32'h0000_0000;
            end
        end else begin
            n.waitreq = 1'b1;
            // readdata shows zero outside its answer cycle
            n.rdata = 32'h0000_0000;
            // writes before the straps land, or in a reset pulse to any word but the strap override, would be lost anyway
            if (avs_write && !s.xtal_locked && !s.dev_rst && s.strap_done) begin
                unique case (avs_address)
                    psm_pkg::OFS_CTRL: begin
                        n.power_down = avs_writedata[psm_pkg::CTRL_PD];
                        n.isolate = avs_writedata[psm_pkg::CTRL_ISO];
                        n.force_gig = avs_writedata[psm_pkg::CTRL_FGIG];
                    end
                    psm_pkg::OFS_EDPD: begin
                        n.edpd_en = avs_writedata[psm_pkg::EDPD_EN];
                        n.mask_timer = avs_writedata[psm_pkg::EDPD_MASK +: 2];
                        n.edpd_timer = avs_writedata[psm_pkg::EDPD_TIMER +: 2];
                        n.random_dis = avs_writedata[psm_pkg::EDPD_RND_DIS];
                        n.pair_sel_en = avs_writedata[psm_pkg::EDPD_PSEL_EN];
                        n.pair_sel = avs_writedata[psm_pkg::EDPD_PSEL +: 2];
                    end
                    psm_pkg::OFS_DEBUG: begin
                        n.gate_override = avs_writedata[psm_pkg::DBG_OVR];
                        n.spd_pll_disable = avs_writedata[psm_pkg::DBG_SPD_PLL];
                        n.energy_sleep_pll_off = avs_writedata[psm_pkg::DBG_ED_PLL];
                        n.crystal_osc_disable = avs_writedata[psm_pkg::DBG_XTAL];
                    end
                    psm_pkg::OFS_STRAP: begin
                        n.spd_pll_dis_mode = avs_writedata[psm_pkg::STRAP_DIS_MODE];
                        n.spd_pll_en_mode = avs_writedata[psm_pkg::STRAP_EN_MODE];
                    end
                    psm_pkg::OFS_EVENT: n.evt = s.evt & ~avs_writedata[1:0];
                    default: n.evt = n.evt;
                endcase
            end
        end

        // straps are caught one cycle after release, then loaded as defaults
        if (!s.strap_done) begin
            n.strap_done = 1'b1;
            n.spd_pll_dis_mode = (mode_strap == psm_pkg::STRAP_SPD_PLL_OFF);
            n.spd_pll_en_mode = (mode_strap == psm_pkg::STRAP_SPD_PLL_ON);
            n.dev_rst = 1'b1;
        end
        if (s.dev_rst) begin
            n = psm_defaults(n);
        end

        // energy detect pair selection
        if (!s.force_gig) begin
            mon_mask = 4'h3;
        end else if (s.pair_sel_en) begin
            mon_mask = 4'h1 << s.pair_sel;
        end else begin
            mon_mask = 4'hf;
        end
        // pair select only narrows the gigabit-forced watch
        raw_energy = |(energy_pairs & mon_mask);

        // energy must persist for the mask time before the port wakes
        mask_target = MASK_W * {22'h0, s.mask_timer} + MASK_W;
        if (!raw_energy) begin
            n.mask_cnt = 24'h00_0000;
            n.energy = 1'b0;
        end else if (s.mask_cnt + 24'h00_0001 >= mask_target) begin
            n.energy = 1'b1;
        end else begin
            n.mask_cnt = s.mask_cnt + 24'h00_0001;
        end
        // next-state view, so a pulse never meets an enabled receive path
        sleep = psm_asleep(n.edpd_en, n.energy);

        // link pulses while asleep; random jitter keeps two sleepers apart
        pulse_target = (PULSE_W << s.edpd_timer)
            + (s.random_dis ? 28'h000_0000 : {20'h0_0000, s.lfsr});
        if (!sleep || coma_hold || n.power_down) begin
            n.pulse_cnt = 28'h000_0000;
        end else if (s.pulse_cnt + 28'h000_0001 >= pulse_target) begin
            n.pulse_cnt = 28'h000_0000;
            n.o_pulse = 1'b1;
            n.lfsr = {s.lfsr[6:0], s.lfsr[7] ^ s.lfsr[5] ^ s.lfsr[4] ^ s.lfsr[3]};
        end else begin
            n.pulse_cnt = s.pulse_cnt + 28'h000_0001;
        end

        // events; a new event beats a same-cycle clear
        coma_free = !coma_hold;
        if (coma_free && s.edpd_en && (n.energy != s.energy)) begin
            n.evt[psm_pkg::EV_ENERGY] = 1'b1;
        end
        if (coma_free && (link_up_in != s.link_seen)) begin
            n.evt[psm_pkg::EV_LINK] = 1'b1;
        end
        n.link_seen = coma_free ? link_up_in : s.link_seen;

        // pll off in either low-power state; its release resets the device
        off_now = (n.power_down && n.spd_pll_disable)
            || (sleep && n.energy_sleep_pll_off);
        n.pll_off = off_now;
        n.o_pll = !off_now;
        // clearing the pll-off bit mid-sleep takes this same reset path
        if (s.pll_off && !off_now) begin
            n.dev_rst = 1'b1;
        end

        // sticky: only the pin reset clears the lock
        if (s.power_down && s.crystal_osc_disable && s.strap_done) begin
            n.xtal_locked = 1'b1;
        end

        // output images
        n.o_rx = coma_free && !n.power_down && !sleep;
        n.o_tx = coma_free && !n.power_down;
        n.o_rclk = n.o_rx;
        n.o_led = (coma_free && !n.power_down && !n.isolate) ? led_req : 2'h0;
        n.o_irq = coma_free && irq_req;
        n.o_link = coma_free && link_up_in && !sleep;
        n.o_trim = cable_len_valid && (cable_len_m < psm_pkg::SHORT_CABLE_M);
        n.o_xtal = !n.xtal_locked;
        n.o_iclk = !n.power_down || n.gate_override;
        n.o_txrx = coma_free && !n.isolate
            && (!n.power_down || n.gate_override);
        n.o_mmd = !n.xtal_locked && (!n.power_down || n.gate_override);
        n.o_mmd1 = !n.xtal_locked && !n.power_down;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            // internal clock, pll, crystal and management wake running so software can reach the part
            s <= '0;
            s.waitreq <= 1'b1;
            s.power_down <= psm_pkg::RST_PD;
            s.lfsr <= 8'h01;
            s.o_xtal <= 1'b1;
            s.o_iclk <= 1'b1;
            s.o_mmd <= 1'b1;
            s.o_mmd1 <= 1'b1;
            s.o_pll <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // every pin is a register field; no logic after the flops
    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.waitreq;
    assign rx_path_enable = s.o_rx;
    assign tx_path_enable = s.o_tx;
    assign rec_clk_enable = s.o_rclk;
    assign led_out = s.o_led;
    assign irq_out = s.o_irq;
    assign link_status = s.o_link;
    assign link_pulse = s.o_pulse;
    assign power_trim = s.o_trim;
    assign pll_enable = s.o_pll;
    assign crystal_enable = s.o_xtal;
    assign int_clk_enable = s.o_iclk;
    assign txrx_clk_enable = s.o_txrx;
    assign mmd_access_ok = s.o_mmd;
    assign mmd1_access_ok = s.o_mmd1;
    assign mgmt_alive = s.o_xtal;
    assign device_reset = s.dev_rst;
endmodule

//--- bench/psm_board_model.sv
`timescale 1ns/1ps
module psm_board_model (
    input wire logic clk,
    input wire logic [22:0] cmd,
    output logic coma_hold,
    output logic [4:0] mode_strap,
    output logic [3:0] energy_pairs,
    output logic [7:0] cable_len_m,
    output logic cable_len_valid,
    output logic link_up_in,
    output logic [1:0] led_req,
    output logic irq_req
);
    logic [22:0] pins = '0;
    // board levels move only on the clock, so straps are stable well before reset release
    always @(posedge clk) begin
        pins <= cmd;
    end
    assign {coma_hold, mode_strap, energy_pairs, cable_len_m} = pins[22:5];
    assign {cable_len_valid, link_up_in, led_req, irq_req} = pins[4:0];
endmodule

//--- bench/psm_power_manager_sva.sv
`timescale 1ns/1ps
module psm_power_manager_sva #(
    parameter int PULSE_CYCLES = psm_pkg::PULSE_CYC,
    parameter int MASK_CYCLES = psm_pkg::MASK_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic coma_hold,
    input wire logic [7:0] cable_len_m,
    input wire logic cable_len_valid,
    input wire logic rx_path_enable,
    input wire logic tx_path_enable,
    input wire logic rec_clk_enable,
    input wire logic [1:0] led_out,
    input wire logic irq_out,
    input wire logic link_status,
    input wire logic link_pulse,
    input wire logic power_trim,
    input wire logic pll_enable,
    input wire logic crystal_enable,
    input wire logic int_clk_enable,
    input wire logic txrx_clk_enable,
    input wire logic mmd_access_ok,
    input wire logic mmd1_access_ok,
    input wire logic mgmt_alive,
    input wire logic device_reset
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    coma_path_a: assert property (
        coma_hold |=> !tx_path_enable && !rx_path_enable && !rec_clk_enable)
        else $error("coma left a data path running");
    coma_quiet_a: assert property (
        coma_hold |=> led_out == 2'h0 && !irq_out && !link_status)
        else $error("coma left an indication active");
    trim_on_a: assert property (
        !reset && cable_len_valid && cable_len_m < 8'h46 |=> power_trim)
        else $error("short cable without trim");
    trim_off_a: assert property (
        !cable_len_valid || cable_len_m >= 8'h46 |=> !power_trim)
        else $error("trim on long or unknown cable");
    sleep_pulse_a: assert property (
        link_pulse |-> tx_path_enable && !rx_path_enable && !link_status)
        else $error("link pulse outside sleep");
    pulse_single_a: assert property (
        link_pulse |=> !link_pulse)
        else $error("link pulse longer than one cycle");
    mmd_gate_a: assert property (
        mmd1_access_ok |-> mmd_access_ok && int_clk_enable)
        else $error("mmd access without clocks");
    txrx_gate_a: assert property (
        txrx_clk_enable |-> int_clk_enable)
        else $error("tx rx clocks while internal clocks gated");
    xtal_lock_a: assert property (
        !crystal_enable |=> !crystal_enable && !mgmt_alive && !mmd1_access_ok)
        else $error("crystal lock released without reset");
    pll_reset_a: assert property (
        $rose(pll_enable) |-> ##[0:2] device_reset)
        else $error("pll restart without device reset");
    reset_pulse_a: assert property (
        device_reset |=> !device_reset)
        else $error("device reset longer than one cycle");
endmodule
bind psm_power_manager psm_power_manager_sva #(
    .PULSE_CYCLES(PULSE_CYCLES), .MASK_CYCLES(MASK_CYCLES)) sva_u (
    .clk(clk), .reset(reset), .coma_hold(coma_hold), .cable_len_m(cable_len_m),
    .cable_len_valid(cable_len_valid), .rx_path_enable(rx_path_enable),
    .tx_path_enable(tx_path_enable), .rec_clk_enable(rec_clk_enable), .led_out(led_out),
    .irq_out(irq_out), .link_status(link_status), .link_pulse(link_pulse),
    .power_trim(power_trim), .pll_enable(pll_enable), .crystal_enable(crystal_enable),
    .int_clk_enable(int_clk_enable), .txrx_clk_enable(txrx_clk_enable),
    .mmd_access_ok(mmd_access_ok), .mmd1_access_ok(mmd1_access_ok),
    .mgmt_alive(mgmt_alive), .device_reset(device_reset));

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int PC = 16;
    typedef struct packed {
        logic coma;
        logic [4:0] strap;
        logic [3:0] pairs;
        logic [7:0] len;
        logic lv;
        logic link;
        logic [1:0] led;
        logic irq;
    } psm_board_t;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    psm_board_t bc = '0;
    logic coma_hold, cable_len_valid, link_up_in, irq_req;
    logic [4:0] mode_strap;
    logic [3:0] energy_pairs;
    logic [7:0] cable_len_m, len8;
    logic [1:0] led_req, led_out;
    logic rx_path_enable, tx_path_enable, rec_clk_enable, irq_out, link_status, link_pulse;
    logic power_trim, pll_enable, crystal_enable, int_clk_enable, txrx_clk_enable;
    logic mmd_access_ok, mmd1_access_ok, mgmt_alive, device_reset;
    int error_cnt = 0;
    int num_checks = 0;
    int m[4];
    int mk[4] = '{7, 511, 15, 3};
    int tc[5] = '{0, 0, 4, 4, 4};
    int te[5] = '{33, 33, 33, 481, 481};
    int tp[5] = '{1, 4, 4, 4, 8};
    int tx[5] = '{1, 0, 1, 0, 1};
    int i;
    always #2 clk = ~clk;
    psm_board_model brd_u (.clk(clk), .cmd(bc), .coma_hold(coma_hold), .mode_strap(mode_strap),
        .energy_pairs(energy_pairs), .cable_len_m(cable_len_m), .cable_len_valid(cable_len_valid),
        .link_up_in(link_up_in), .led_req(led_req), .irq_req(irq_req));
    psm_power_manager #(.PULSE_CYCLES(PC), .MASK_CYCLES(4)) dut_u (.clk(clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .coma_hold(coma_hold), .mode_strap(mode_strap),
        .energy_pairs(energy_pairs), .cable_len_m(cable_len_m), .cable_len_valid(cable_len_valid),
        .link_up_in(link_up_in), .led_req(led_req), .irq_req(irq_req),
        .rx_path_enable(rx_path_enable), .tx_path_enable(tx_path_enable),
        .rec_clk_enable(rec_clk_enable), .led_out(led_out), .irq_out(irq_out),
        .link_status(link_status), .link_pulse(link_pulse), .power_trim(power_trim),
        .pll_enable(pll_enable), .crystal_enable(crystal_enable), .int_clk_enable(int_clk_enable),
        .txrx_clk_enable(txrx_clk_enable), .mmd_access_ok(mmd_access_ok),
        .mmd1_access_ok(mmd1_access_ok), .mgmt_alive(mgmt_alive), .device_reset(device_reset));
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic lim(input int n);
        if (n >= 300) begin
            error_cnt++;
            conclude();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // avalon master: hold everything until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 300);
        lim(n);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input int d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        if (a < 5'h10) m[a[3:2]] = d & mk[a[3:2]];
    endtask
    task automatic rd(input logic [4:0] a, input int mask, input int exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(q & mask, exp);
    endtask
    // defaults after a device reset come from the strap override word
    task automatic wait_dr();
        int n;
        n = 0;
        while (device_reset !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        lim(n);
        m[0] = (m[3] != 0);
        m[1] = 0;
        m[2] = m[3][0] ? 2 : 0;
        cyc(3);
    endtask
    task automatic do_reset(input logic [4:0] s, input int c, input int d, input int st);
        bc.strap <= s;
        reset <= 1'b1;
        cyc(5);
        reset <= 1'b0;
        cyc(4);
        m = '{c, 0, d, st};
    endtask
    task automatic pint(input int exp, input int jit);
        int n;
        n = 0;
        while (link_pulse !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        lim(n);
        @(posedge clk);
        n = 1;
        while (link_pulse !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        lim(n);
        chk((n >= exp && n <= exp + jit) ? exp : n, exp);
    endtask
    initial begin
        void'($urandom(32'h23bb_15e7));
        do_reset(5'h00, 0, 0, 0);
        rd(psm_pkg::OFS_EDPD, 511, m[1]);
        rd(5'h18, -1, 0);
        bc.link <= 1'b1;
        bc.led <= 2'h3;
        bc.irq <= 1'b1;
        cyc(3);
        chk({led_out, irq_out, link_status, tx_path_enable}, 5'h1f);
        wr(psm_pkg::OFS_EVENT, 3);
        bc.coma <= 1'b1;
        cyc(2);
        bc.link <= 1'b0;
        cyc(3);
        chk({led_out, irq_out, link_status, tx_path_enable, rx_path_enable, rec_clk_enable}, 0);
        rd(psm_pkg::OFS_EVENT, 3, 0);
        rd(psm_pkg::OFS_STATUS, 4, 4);
        bc.coma <= 1'b0;
        bc.link <= 1'b1;
        cyc(3);
        chk({tx_path_enable, rx_path_enable, led_out}, 4'hf);
        for (i = 0; i < 12; i++) begin
            len8 = (i < 2) ? 8'(69 + i) : 8'($urandom);
            bc.len <= len8;
            bc.lv <= 1'b1;
            cyc(3);
            chk(power_trim, len8 < 8'h46);
        end
        for (i = 0; i < 4; i++) begin
            wr(psm_pkg::OFS_EDPD, 33 | (i << 3));
            pint(PC << i, 0);
        end
        chk({tx_path_enable, rx_path_enable, link_status}, 3'h4);
        rd(psm_pkg::OFS_STATUS, 1, 1);
        wr(psm_pkg::OFS_EDPD, 7);
        pint(PC, 255);
        bc.pairs <= 4'h1;
        cyc(12);
        chk(link_status, 0);
        cyc(8);
        chk(link_status, 1);
        for (i = 0; i < 5; i++) begin
            wr(psm_pkg::OFS_CTRL, tc[i]);
            wr(psm_pkg::OFS_EDPD, te[i]);
            bc.pairs <= 4'(tp[i]);
            cyc(30);
            rd(psm_pkg::OFS_STATUS, 3, tx[i] ? 2 : 1);
            chk(link_status, tx[i]);
        end
        rd(psm_pkg::OFS_EVENT, 1, 1);
        wr(psm_pkg::OFS_EVENT, 1);
        rd(psm_pkg::OFS_EVENT, 1, 0);
        wr(psm_pkg::OFS_CTRL, 0);
        bc.pairs <= 4'h0;
        cyc(10);
        chk(pll_enable, 1);
        wr(psm_pkg::OFS_DEBUG, 4);
        cyc(3);
        chk(pll_enable, 0);
        bc.pairs <= 4'h1;
        wait_dr();
        rd(psm_pkg::OFS_EDPD, 511, m[1]);
        rd(psm_pkg::OFS_DEBUG, 15, m[2]);
        wr(psm_pkg::OFS_CTRL, 1);
        cyc(3);
        chk({int_clk_enable, txrx_clk_enable, mmd_access_ok, mmd1_access_ok, pll_enable,
             crystal_enable}, 6'h03);
        wr(psm_pkg::OFS_DEBUG, 1);
        cyc(3);
        chk({int_clk_enable, txrx_clk_enable, mmd_access_ok, mmd1_access_ok}, 4'he);
        wr(psm_pkg::OFS_CTRL, 3);
        cyc(3);
        chk(txrx_clk_enable, 0);
        wr(psm_pkg::OFS_CTRL, 0);
        cyc(3);
        rd(psm_pkg::OFS_DEBUG, 15, m[2]);
        wr(psm_pkg::OFS_DEBUG, 2);
        wr(psm_pkg::OFS_CTRL, 1);
        cyc(3);
        chk(pll_enable, 0);
        wr(psm_pkg::OFS_CTRL, 0);
        wait_dr();
        rd(psm_pkg::OFS_DEBUG, 15, m[2]);
        do_reset(5'h09, 1, 2, 1);
        chk({pll_enable, int_clk_enable}, 0);
        rd(psm_pkg::OFS_CTRL, 7, m[0]);
        wr(psm_pkg::OFS_STRAP, 0);
        wr(psm_pkg::OFS_CTRL, 0);
        wait_dr();
        rd(psm_pkg::OFS_CTRL, 7, m[0]);
        do_reset(5'h08, 1, 0, 2);
        chk({pll_enable, int_clk_enable}, 2'h2);
        wr(psm_pkg::OFS_DEBUG, 2);
        wr(psm_pkg::OFS_CTRL, 0);
        wait_dr();
        rd(psm_pkg::OFS_CTRL, 7, m[0]);
        wr(psm_pkg::OFS_DEBUG, 8);
        cyc(3);
        chk({crystal_enable, mgmt_alive, mmd_access_ok}, 0);
        rd(psm_pkg::OFS_CTRL, 7, 0);
        do_reset(5'h00, 0, 0, 0);
        chk({crystal_enable, mgmt_alive}, 2'h3);
        conclude();
    end
endmodule
